//--- rtl/sfm_consts.svh
// Purpose: Constants for the sensor fault monitor
// Assumes: 25 MHz system clock; sensor readings already converted to mV and degrees C
// Notes:   Times keep their printed unit; cycle counts derive from the clock rate
`ifndef SFM_CONSTS_SVH
`define SFM_CONSTS_SVH

`define SFM_CLK_KHZ 64'd25000

// Qualifying times in ms
`define SFM_T_COOL_MS 64'd200
`define SFM_T_O2_COLD_MS 64'd500
`define SFM_T_O2_WARM_MS 64'd30000
`define SFM_T_O2_HIGH_MS 64'd20000
`define SFM_T_RUN_O2_MS 64'd75000
`define SFM_T_RUN_LONG_MS 64'd300000

// Coolant limits, degrees C, signed 9 bits
`define SFM_COOL_HOT_C 9'sd135
`define SFM_COOL_COLD_C -9'sd42

// Throttle limits in mV; scaling gain, shift and percent values
`define SFM_TP_LOW_MV 13'd200
`define SFM_TP_HIGH_MV 13'd4800
`define SFM_TP_ZERO_MIN_MV 13'd350
`define SFM_TP_ZERO_MAX_MV 13'd700
`define SFM_TP_ZERO_RST_MV 13'h1f4
`define SFM_TP_GAIN 16'd5
`define SFM_TP_SHIFT 8
`define SFM_TP_SUBST_PCT 7'd14
`define SFM_TP_MAX_PCT 7'd100

// Oxygen limits, mV
`define SFM_O2_COLD_MV 11'd40
`define SFM_O2_WARM_LO_MV 11'd60
`define SFM_O2_WARM_HI_MV 11'd390
`define SFM_O2_DOWN_MV 11'd500
`define SFM_O2_HIGH_MV 11'd1100

// Drive cycles before the lamp is requested
`define SFM_LAMP_CYCLES 2'd2

// Code bit positions
`define SFM_CODE_COOL_LOW 0
`define SFM_CODE_COOL_HIGH 1
`define SFM_CODE_TP_LOW 2
`define SFM_CODE_TP_HIGH 3
`define SFM_CODE_O2_UP_BAD 4
`define SFM_CODE_O2_UP_HIGH 5
`define SFM_NCODES 6
`define SFM_NTIMERS 7

`endif

//--- rtl/sfm_pkg.sv
// Purpose: Types shared by the sensor fault monitor
// Assumes: Constants come from sfm_consts.svh
// Notes:   Types only
package sfm_pkg;
    typedef logic [5:0] sfm_codes_t;
    typedef logic [6:0] sfm_pct_t;
    typedef logic [12:0] sfm_tp_mv_t;
    typedef logic [10:0] sfm_o2_mv_t;
    typedef logic signed [8:0] sfm_temp_t;
    typedef logic [32:0] sfm_cyc_t;
endpackage

//--- rtl/sfm_qual_timer.sv
// Purpose: Qualifying-duration timer: done once its condition has held LIMIT cycles
// Assumes: Condition comes from logic on the same clock
// Notes:   Any lapse of the condition restarts the count from zero
`timescale 1ns/1ps
module sfm_qual_timer #(
    parameter sfm_pkg::sfm_cyc_t LIMIT = 33'h000000001
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Condition
    input wire logic i_cond,
    input wire logic i_clear,
    // Result
    output logic o_done
);
    import sfm_pkg::*;

    sfm_cyc_t cnt;
    wire hold = (cnt == LIMIT);

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= '0;
        end else if (!i_cond || i_clear) begin
            cnt <= '0;
        end else if (!hold) begin
            cnt <= cnt + 33'h000000001;
        end
    end

    assign o_done = hold;

    a_restart_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !i_cond |=> (cnt == '0) && !o_done)
        else $error("timer did not restart after condition lapse");
endmodule

//--- rtl/sfm_fault_monitor.sv
// Purpose: Sensor fault monitor: qualifies sensor faults, stores codes, lamp delay, throttle scaling
// Assumes: Sensor readings are same-clock converted values; status strobes arrive from pins
// Notes:   Engine run-time timers are not erased by a code clear
// Operation
// - Engine running, coolant above 135C 0.2s records code
// - Engine running, coolant below -42C 0.2s records code
// - Lamp requested only after two drive cycles
// - Engine running, throttle below 0.2V records code
// - Engine running, throttle above 4.8V records code
// - Closed throttle within 0.35-0.7V becomes zero
// - Throttle-low fault, ignition on: report 14 percent
// - Scale throttle to monotonic percent from zero
// - Upstream oxygen check waits 75s of running
// - Cold upstream below 40mV 0.5s records code
// - Warm upstream 60-390mV, downstream over 0.5V, 30s
// - After 5 minutes, upstream above 1.1V 20s
`timescale 1ns/1ps
`include "sfm_consts.svh"
module sfm_fault_monitor #(
    parameter sfm_pkg::sfm_cyc_t T_COOL_CYC = 33'(`SFM_T_COOL_MS * `SFM_CLK_KHZ),
    parameter sfm_pkg::sfm_cyc_t T_O2_COLD_CYC = 33'(`SFM_T_O2_COLD_MS * `SFM_CLK_KHZ),
    parameter sfm_pkg::sfm_cyc_t T_O2_WARM_CYC = 33'(`SFM_T_O2_WARM_MS * `SFM_CLK_KHZ),
    parameter sfm_pkg::sfm_cyc_t T_O2_HIGH_CYC = 33'(`SFM_T_O2_HIGH_MS * `SFM_CLK_KHZ),
    parameter sfm_pkg::sfm_cyc_t T_RUN_O2_CYC = 33'(`SFM_T_RUN_O2_MS * `SFM_CLK_KHZ),
    parameter sfm_pkg::sfm_cyc_t T_RUN_LONG_CYC = 33'(`SFM_T_RUN_LONG_MS * `SFM_CLK_KHZ)
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Status pins, asynchronous to the clock
    input wire logic i_engine_running,
    input wire logic i_ignition_on,
    input wire logic i_drive_cycle_done,
    input wire logic i_clear_codes,
    input wire logic i_throttle_closed,
    // Converted sensor readings, same clock
    input wire sfm_pkg::sfm_temp_t i_coolant_temp_sensor,
    input wire sfm_pkg::sfm_tp_mv_t i_throttle_sensor,
    input wire sfm_pkg::sfm_o2_mv_t i_upstream_oxygen_voltage,
    input wire sfm_pkg::sfm_o2_mv_t i_downstream_oxygen_voltage,
    input wire logic i_upstream_warm,
    // Results
    output sfm_pkg::sfm_codes_t o_stored_codes,
    output logic o_warning_lamp_request,
    output sfm_pkg::sfm_pct_t o_throttle_opening_percent
);
    import sfm_pkg::*;

    // Pin synchronisers: stage one feeds stage two only
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync_prev;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
            sync_prev <= 5'h00;
        end else begin
            sync1 <= {i_throttle_closed, i_clear_codes, i_drive_cycle_done, i_ignition_on, i_engine_running};
            sync2 <= sync1;
            sync_prev <= sync2;
        end
    end

    wire run_s = sync2[0];
    wire ign_s = sync2[1];
    wire dc_pulse = sync2[2] && !sync_prev[2];
    wire clr_pulse = sync2[3] && !sync_prev[3];
    wire closed_s = sync2[4];

    // Qualifying timers
    localparam sfm_cyc_t LIMITS [`SFM_NTIMERS] = '{T_COOL_CYC, T_COOL_CYC, T_O2_COLD_CYC, T_O2_WARM_CYC,
                                                   T_O2_HIGH_CYC, T_RUN_O2_CYC, T_RUN_LONG_CYC};
    logic [`SFM_NTIMERS-1:0] t_cond;
    logic [`SFM_NTIMERS-1:0] t_clear;
    logic [`SFM_NTIMERS-1:0] t_done;

    wire run_o2 = t_done[5];
    wire run_long = t_done[6];
    wire up_cold = i_upstream_oxygen_voltage < `SFM_O2_COLD_MV;
    wire up_mid = (i_upstream_oxygen_voltage > `SFM_O2_WARM_LO_MV) &&
                  (i_upstream_oxygen_voltage < `SFM_O2_WARM_HI_MV);
    wire down_rich = i_downstream_oxygen_voltage > `SFM_O2_DOWN_MV;
    wire up_high = i_upstream_oxygen_voltage > `SFM_O2_HIGH_MV;

    assign t_cond[0] = run_s && (i_coolant_temp_sensor > `SFM_COOL_HOT_C);
    assign t_cond[1] = run_s && (i_coolant_temp_sensor < `SFM_COOL_COLD_C);
    assign t_cond[2] = run_o2 && !i_upstream_warm && up_cold;
    assign t_cond[3] = run_o2 && i_upstream_warm && up_mid && down_rich;
    assign t_cond[4] = run_long && up_high;
    assign t_cond[5] = run_s;
    assign t_cond[6] = run_s;
    // A clear restarts every fault timer so conditions qualify afresh
    assign t_clear = {2'b00, {5{clr_pulse}}};

    genvar g;
    generate
        for (g = 0; g < `SFM_NTIMERS; g++) begin : gen_timer
            sfm_qual_timer #(
                .LIMIT(LIMITS[g])
            ) u_timer (
                .i_mclk(i_mclk),
                .i_rst_b(i_rst_b),
                .i_cond(t_cond[g]),
                .i_clear(t_clear[g]),
                .o_done(t_done[g])
            );
        end
    endgenerate

    // Code setting
    wire tp_low = i_throttle_sensor < `SFM_TP_LOW_MV;
    wire tp_high = i_throttle_sensor > `SFM_TP_HIGH_MV;
    sfm_codes_t set_vec;
    assign set_vec[`SFM_CODE_COOL_LOW] = run_s && t_done[0];
    assign set_vec[`SFM_CODE_COOL_HIGH] = run_s && t_done[1];
    assign set_vec[`SFM_CODE_TP_LOW] = run_s && tp_low;
    assign set_vec[`SFM_CODE_TP_HIGH] = run_s && tp_high;
    assign set_vec[`SFM_CODE_O2_UP_BAD] = t_done[2] || t_done[3];
    assign set_vec[`SFM_CODE_O2_UP_HIGH] = t_done[4];

    // A fault qualifying in the clear cycle is kept, not lost
    wire sfm_codes_t next_codes = (clr_pulse ? '0 : o_stored_codes) | set_vec;

    // Lamp delay: each stored code counts completed drive cycles
    logic [1:0] dc_cnt [`SFM_NCODES];
    sfm_codes_t lamp_hit;
    generate
        for (g = 0; g < `SFM_NCODES; g++) begin : gen_lamp
            always_ff @(posedge i_mclk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    dc_cnt[g] <= 2'h0;
                end else if (clr_pulse) begin
                    dc_cnt[g] <= 2'h0;
                end else if (o_stored_codes[g] && dc_pulse && dc_cnt[g] != `SFM_LAMP_CYCLES) begin
                    dc_cnt[g] <= dc_cnt[g] + 2'h1;
                end
            end
            assign lamp_hit[g] = o_stored_codes[g] && (dc_cnt[g] == `SFM_LAMP_CYCLES);
        end
    endgenerate
    wire next_lamp = |lamp_hit && !clr_pulse;

    // Throttle auto-zero and percent scaling
    sfm_tp_mv_t zero_ref;
    wire adopt_zero = closed_s && (i_throttle_sensor >= `SFM_TP_ZERO_MIN_MV) &&
                      (i_throttle_sensor <= `SFM_TP_ZERO_MAX_MV);
    wire sfm_tp_mv_t tp_span = (i_throttle_sensor > zero_ref) ? (i_throttle_sensor - zero_ref) : '0;
    wire [15:0] tp_prod = 16'(tp_span * `SFM_TP_GAIN);
    wire [7:0] tp_raw = tp_prod[15:`SFM_TP_SHIFT];
    // Saturate rather than wrap so the percent never falls as the throttle opens
    wire sfm_pct_t tp_scaled = (tp_raw > 8'(`SFM_TP_MAX_PCT)) ? `SFM_TP_MAX_PCT : tp_raw[6:0];
    wire subst_pct = o_stored_codes[`SFM_CODE_TP_LOW] && ign_s;
    wire sfm_pct_t next_pct = subst_pct ? `SFM_TP_SUBST_PCT : tp_scaled;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_stored_codes <= '0;
            o_warning_lamp_request <= 1'b0;
            o_throttle_opening_percent <= 7'h00;
            zero_ref <= `SFM_TP_ZERO_RST_MV;
        end else begin
            o_stored_codes <= next_codes;
            o_warning_lamp_request <= next_lamp;
            o_throttle_opening_percent <= next_pct;
            if (adopt_zero) begin
                zero_ref <= i_throttle_sensor;
            end
        end
    end

    // Checks
    a_cool_low_cause: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_stored_codes[`SFM_CODE_COOL_LOW]) |-> $past(run_s && t_done[0]))
        else $error("coolant low code set without qualified hot reading");
    a_cool_high_cause: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_stored_codes[`SFM_CODE_COOL_HIGH]) |-> $past(run_s && t_done[1]))
        else $error("coolant high code set without qualified cold reading");
    a_lamp_needs_cycles: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_warning_lamp_request) |-> $past(|lamp_hit) && |o_stored_codes)
        else $error("lamp requested before two drive cycles");
    a_tp_low_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (run_s && tp_low) |=> o_stored_codes[`SFM_CODE_TP_LOW])
        else $error("throttle low code not recorded");
    a_tp_high_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (run_s && tp_high) |=> o_stored_codes[`SFM_CODE_TP_HIGH])
        else $error("throttle high code not recorded");
    a_zero_window: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        ##1 (zero_ref >= `SFM_TP_ZERO_MIN_MV) && (zero_ref <= `SFM_TP_ZERO_MAX_MV))
        else $error("zero reference outside adoption window");
    a_subst_pct: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        subst_pct |=> o_throttle_opening_percent == `SFM_TP_SUBST_PCT)
        else $error("substitute throttle percent not reported");
    a_pct_closed_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (!subst_pct && i_throttle_sensor <= zero_ref) |=> o_throttle_opening_percent == 7'h00)
        else $error("closed throttle not scaled to zero");
    a_pct_ceiling: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_throttle_opening_percent <= `SFM_TP_MAX_PCT)
        else $error("throttle percent above full scale");
    a_o2_run_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_stored_codes[`SFM_CODE_O2_UP_BAD]) |-> $past(run_o2))
        else $error("upstream oxygen code before run time elapsed");
    a_o2_high_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_stored_codes[`SFM_CODE_O2_UP_HIGH]) |-> $past(run_long && up_high))
        else $error("upstream high code without long run and high reading");
    a_clear_erases: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (clr_pulse && set_vec == '0) |=> o_stored_codes == '0 ##1 !o_warning_lamp_request)
        else $error("clear request did not erase codes");
    // Only a tester clear may drop a stored code; a lost bit would hide a fault
    a_codes_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !clr_pulse |=> (o_stored_codes & $past(o_stored_codes)) == $past(o_stored_codes))
        else $error("stored code lost without a clear");

    c_lamp_on: cover property (@(posedge i_mclk) disable iff (!i_rst_b) $rose(o_warning_lamp_request));
    c_o2_bad: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_stored_codes[`SFM_CODE_O2_UP_BAD]));
    c_tp_low: cover property (@(posedge i_mclk) disable iff (!i_rst_b) $rose(o_stored_codes[`SFM_CODE_TP_LOW]));
    c_zero_adopt: cover property (@(posedge i_mclk) disable iff (!i_rst_b) adopt_zero);
    c_clear: cover property (@(posedge i_mclk) disable iff (!i_rst_b) clr_pulse && |o_stored_codes);
endmodule

//--- dv/sfm_sensor_model.sv
// Purpose: Sensor side model: converter channels handing readings to the monitor
// Assumes: Bench commands each reading; one conversion per clock
// Notes:   Readings land one edge after the command, like a registered converter
`timescale 1ns/1ps
module sfm_sensor_model
    import sfm_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Commanded physical values
    input wire sfm_pkg::sfm_temp_t i_cool,
    input wire sfm_pkg::sfm_tp_mv_t i_thr,
    input wire sfm_pkg::sfm_o2_mv_t i_up,
    input wire sfm_pkg::sfm_o2_mv_t i_dn,
    input wire logic i_warm,
    // Converted readings
    output sfm_pkg::sfm_temp_t o_cool,
    output sfm_pkg::sfm_tp_mv_t o_thr,
    output sfm_pkg::sfm_o2_mv_t o_up,
    output sfm_pkg::sfm_o2_mv_t o_dn,
    output logic o_warm
);
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            // Mid-range readings so no fault shows during reset
            {o_cool, o_thr, o_up, o_dn, o_warm} <= {9'sh014, 13'h3e8, 11'h1c2, 11'h1c2, 1'h0};
        end else begin
            {o_cool, o_thr, o_up, o_dn, o_warm} <= {i_cool, i_thr, i_up, i_dn, i_warm};
        end
    end
endmodule

//--- dv/sfm_fault_monitor_bench.sv
// Purpose: Self-checking bench for the sensor fault monitor
// Assumes: Shortened qualifying counts; readings come through the sensor model
// Notes:   Waits for codes are bounded; early-set checks use counts below the limits
`timescale 1ns/1ps
module sfm_fault_monitor_bench;
    import sfm_pkg::*;
    logic i_mclk = 1'b0, i_rst_b = 1'b0, run = 1'b0, ign = 1'b0, dcy = 1'b0, clr_p = 1'b0, closed = 1'b0;
    sfm_temp_t cool = 9'sh014, cool_s;
    sfm_tp_mv_t thr = 13'h3e8, thr_s;
    sfm_o2_mv_t up = 11'h1c2, dn = 11'h1c2, up_s, dn_s;
    logic warm = 1'b0, warm_s, lamp;
    sfm_codes_t codes;
    sfm_pct_t pct;
    int err_total = 0, checks = 0, cyc_cnt = 0;
    sfm_tp_mv_t r;
    sfm_sensor_model i_model (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cool(cool), .i_thr(thr), .i_up(up),
        .i_dn(dn), .i_warm(warm), .o_cool(cool_s), .o_thr(thr_s), .o_up(up_s), .o_dn(dn_s), .o_warm(warm_s));
    // Short qualifying counts keep every timed fault within a few hundred clocks
    localparam sfm_cyc_t T_COOL = 33'd10, T_COLD = 33'd12, T_WARM = 33'd40;
    localparam sfm_cyc_t T_HIGH = 33'd30, T_RUN = 33'd50, T_LONG = 33'd100;
    sfm_fault_monitor #(.T_COOL_CYC(T_COOL), .T_O2_COLD_CYC(T_COLD), .T_O2_WARM_CYC(T_WARM),
        .T_O2_HIGH_CYC(T_HIGH), .T_RUN_O2_CYC(T_RUN), .T_RUN_LONG_CYC(T_LONG)) i_dut (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_engine_running(run), .i_ignition_on(ign),
        .i_drive_cycle_done(dcy), .i_clear_codes(clr_p), .i_throttle_closed(closed),
        .i_coolant_temp_sensor(cool_s), .i_throttle_sensor(thr_s), .i_upstream_oxygen_voltage(up_s),
        .i_downstream_oxygen_voltage(dn_s), .i_upstream_warm(warm_s), .o_stored_codes(codes),
        .o_warning_lamp_request(lamp), .o_throttle_opening_percent(pct));
    initial begin
        forever #20 i_mclk = ~i_mclk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic fail(input string m);
        err_total++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic chk_codes(input sfm_codes_t e);
        checks++;
        if (codes !== e) fail($sformatf("codes %b want %b", codes, e));
    endtask
    task automatic chk_lamp(input logic e);
        checks++;
        if (lamp !== e) fail("lamp request wrong");
    endtask
    task automatic chk_pct(input sfm_pct_t e);
        checks++;
        if (pct !== e) fail($sformatf("percent %0d want %0d", pct, e));
    endtask
    // Bounded wait for one code bit, then the whole code word is compared
    task automatic wait_code(input int b, input int lim, input sfm_codes_t e);
        for (int i = 0; i < lim && codes[b] !== 1'b1; i++) cyc(1);
        chk_codes(e);
    endtask
    // Strobe pins are held high and low well over two clocks each
    task automatic strobe(input bit is_clr);
        @(posedge i_mclk);
        if (is_clr) clr_p <= 1'b1;
        else dcy <= 1'b1;
        cyc(3);
        clr_p <= 1'b0;
        dcy <= 1'b0;
        cyc(4);
    endtask
    function automatic sfm_pct_t exp_pct(input sfm_tp_mv_t v, input sfm_tp_mv_t z);
        logic [31:0] p;
        p = (v > z) ? ((32'(v - z) * 32'h5) >> 8) : 32'h0;
        return (p > 32'h64) ? 7'h64 : p[6:0];
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            fail("timeout");
            test_done;
        end
    end
    initial begin
        void'($urandom(32'h0c76));
        cyc(5);
        i_rst_b <= 1'b1;
        run <= 1'b1;
        thr <= 13'h0c8;
        cyc(10);
        chk_codes(6'h00);
        thr <= 13'h12c0;
        cyc(10);
        chk_codes(6'h00);
        thr <= 13'h096;
        wait_code(2, 10, 6'h04);
        ign <= 1'b1;
        cyc(6);
        chk_pct(7'h0e);
        thr <= 13'h12c1;
        wait_code(3, 10, 6'h0c);
        thr <= 13'h3e8;
        ign <= 1'b0;
        chk_lamp(1'b0);
        strobe(1'b0);
        chk_lamp(1'b0);
        strobe(1'b0);
        chk_lamp(1'b1);
        strobe(1'b1);
        chk_codes(6'h00);
        chk_lamp(1'b0);
        $display("throttle limits and lamp done");
        cool <= 9'sh088;
        cyc(8);
        cool <= 9'sh014;
        cyc(1);
        cool <= 9'sh088;
        cyc(8);
        chk_codes(6'h00);
        wait_code(0, 8, 6'h01);
        cool <= -9'sh02b;
        wait_code(1, 16, 6'h03);
        cool <= 9'sh014;
        strobe(1'b1);
        chk_codes(6'h00);
        $display("coolant done");
        run <= 1'b0;
        cyc(5);
        run <= 1'b1;
        up <= 11'h01e;
        cyc(30);
        chk_codes(6'h00);
        wait_code(4, 40, 6'h10);
        up <= 11'h4b0;
        wait_code(5, 120, 6'h30);
        up <= 11'h1c2;
        strobe(1'b1);
        chk_codes(6'h00);
        warm <= 1'b1;
        up <= 11'h0c8;
        dn <= 11'h258;
        cyc(30);
        chk_codes(6'h00);
        wait_code(4, 20, 6'h10);
        up <= 11'h1c2;
        strobe(1'b1);
        chk_codes(6'h00);
        $display("oxygen done");
        closed <= 1'b1;
        thr <= 13'h258;
        cyc(6);
        closed <= 1'b0;
        chk_pct(7'h00);
        for (int i = 0; i < 24; i++) begin
            // Stay above the adoption window while the closed pin is still draining
            r = 13'($urandom_range(701, 4799));
            thr <= r;
            cyc(3);
            chk_pct(exp_pct(r, 13'h258));
        end
        closed <= 1'b1;
        thr <= 13'h320;
        cyc(6);
        closed <= 1'b0;
        thr <= 13'h640;
        cyc(3);
        chk_pct(exp_pct(13'h640, 13'h258));
        chk_codes(6'h00);
        $display("scaling done");
        test_done;
    end
endmodule
